// ==== verilog/dual_timer_consts.vh ====
// constants for the dual timer block: offsets, field positions, reset values
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH

// word offsets per timer (byte address = 4 * index), timer b adds the stride
`define TMR_EVT_IRQ_IDX     4'h0
`define TMR_PRESCALE_IDX    4'h1
`define TMR_MODE_CLK_IDX    4'h2
`define TMR_CAP_OUT_IDX     4'h3
`define TMR_COUNT_IDX       4'h4
`define TMR_MATCH1_IDX      4'h5
`define TMR_MATCH2_IDX      4'h6
`define TMR_CAPT1_IDX       4'h7
`define TMR_CAPT2_IDX       4'h8
`define TMR_B_BASE          4'h9
`define PAIR_CTRL_IDX       5'h12

// event / irq control fields
`define EV_OVF_IE           7
`define EV_SEC_IE           6
`define EV_CAP1_IE          5
`define EV_CMP1_IE          4
`define EV_OVF_F            3
`define EV_SEC_F            2
`define EV_CAP1_F           1
`define EV_CMP1_F           0

// mode / clock fields
`define MC_MODE             7
`define MC_OEN              6
`define MC_EXTERNAL_CLOCK_ENABLE           5
`define MC_CAP2EN           4
`define MC_CAP1EN           3
`define MC_EXTERNAL_CLOCK_EDGE_SELECT          2
`define MC_CAPRST           1
`define MC_RUN              0

// capture / output fields
`define CO_FORCE_HI         6
`define CO_FORCE_LO         5
`define CO_TIE              4
`define CO_EDG2_HI          3
`define CO_EDG2_LO          2
`define CO_EDG1_HI          1
`define CO_EDG1_LO          0

// pair control fields
`define PC_B_IE             5
`define PC_A_IE             4
`define PC_B_CLR            1
`define PC_A_CLR            0

// edge codes and reset values
`define EDGE_FALL           2'h0
`define EDGE_RISE           2'h1
`define CFG_RST             8'h00
`define CNT_WIDTH           16
`define CNT_RST             16'h0000

`endif

// ==== verilog/dual_timer_capture_compare_pwm.v ====
// two identical capture/compare/pwm timers behind an avalon-mm slave
// Behaviour
// - overflow irq enable gates overflow interrupt
// - overflow sets sticky flag until software clears
// - second enable gates match2 or capture2 irq
// - second flag set by match2 or capture2
// - capture1 sets sticky flag, enable gates irq
// - match1 sets sticky flag, enable gates irq
// - four-bit prescaler divides by two power n
// - output enable lets timer drive output pin
// - external clock enable selects pin clock
// - external edge select rising/falling, else ignored
// - capture1 input enable routes capture1 pin
// - capture-clears-counter bit clears on capture1
// - run enable runs timer, off gates clock
// - force-high write one sets output, reads zero
// - force-low write one clears output, reads zero; force-high wins when both bits are written
// - tie bit feeds capture1 pin into capture2
// - capture2 edge: 00 fall, 01 rise, else both
// - capture1 edge: 00 fall, 01 rise, else both
// - pair control holds per-timer irq enables
// - per-timer clear bit zeroes counter, reads zero
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

// per timer: +0 events, +1 prescale, +2 mode, +3 capture/output,
// +4 count, +5/+6 match, +7/+8 capture; timer b from its own base
// pins are taken as already synchronous to i_ref_clk
// every register clears on reset; the counter is 16 bits wide

module dual_timer_capture_compare_pwm (
    input  wire        i_ref_clk,
    input  wire        i_reset,
    input  wire [6:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    input  wire [1:0]  i_timer_external_clock_pin,
    input  wire [1:0]  i_first_capture_pin,
    input  wire [1:0]  i_second_capture_pin,
    output wire [1:0]  o_timer_output_pin,
    output wire [1:0]  o_timer_output_pin_oe_n,
    output wire [1:0]  o_timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle on every access, then a single-cycle ack
    // the wait cycle buys a registered read path for half the bus rate
    // only byte lane 0 qualifies a write
    reg         ack_ff;
    reg  [31:0] rdata_ff;
    wire        req      = i_avs_read | i_avs_write;
    wire        wr_take  = i_avs_write & ack_ff & i_avs_byteenable[0];
    wire [4:0]  word_idx = i_avs_address[6:2];

    assign o_avs_waitrequest = req & ~ack_ff;
    assign o_avs_readdata    = rdata_ff;

    // ack toggles so back-to-back requests each see a wait cycle
    // a request held past its ack starts a fresh access
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pair control: irq enables stored, clear bits are write pulses only
    // clears are never stored, so they read back as zero
    reg  [1:0] pair_ie_ff;
    wire       pair_wr = wr_take & (word_idx == `PAIR_CTRL_IDX);
    wire [1:0] clr_pulse = pair_wr ?
        {i_avs_writedata[`PC_B_CLR], i_avs_writedata[`PC_A_CLR]} : 2'b00;

    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            pair_ie_ff <= 2'b00;
        end else if (pair_wr) begin
            pair_ie_ff <= {i_avs_writedata[`PC_B_IE], i_avs_writedata[`PC_A_IE]};
        end
    end

    // per-timer read values collected for the read mux
    // index 0 is timer a, index 1 is timer b
    wire [7:0]  rd_evt   [0:1];
    wire [7:0]  rd_psc   [0:1];
    wire [7:0]  rd_mc    [0:1];
    wire [7:0]  rd_co    [0:1];
    wire [15:0] rd_cnt   [0:1];
    wire [15:0] rd_m1    [0:1];
    wire [15:0] rd_m2    [0:1];
    wire [15:0] rd_c1    [0:1];
    wire [15:0] rd_c2    [0:1];

    ////////////////////////////////////////////////////////////////////////
    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : g_tmr
            // decode relative to this timer's base; strobes last one cycle
            // configuration registers use the low byte, match registers the low half-word
            wire [4:0] base = (t == 0) ? 5'h00 : {1'b0, `TMR_B_BASE};
            wire [4:0] rel  = word_idx - base;
            wire       hit  = (word_idx >= base) && (rel <= {1'b0, `TMR_CAPT2_IDX});
            wire       w_ev = wr_take & hit & (rel == {1'b0, `TMR_EVT_IRQ_IDX});
            wire       w_ps = wr_take & hit & (rel == {1'b0, `TMR_PRESCALE_IDX});
            wire       w_mc = wr_take & hit & (rel == {1'b0, `TMR_MODE_CLK_IDX});
            wire       w_co = wr_take & hit & (rel == {1'b0, `TMR_CAP_OUT_IDX});
            wire       w_m1 = wr_take & hit & (rel == {1'b0, `TMR_MATCH1_IDX});
            wire       w_m2 = wr_take & hit & (rel == {1'b0, `TMR_MATCH2_IDX});
            wire [7:0] wd   = i_avs_writedata[7:0];

            // per-timer state
            reg  [3:0]  ie_ff;
            reg  [3:0]  flag_ff;
            reg  [3:0]  psc_ff;
            reg  [7:0]  mc_ff;
            reg  [4:0]  co_ff;
            reg  [15:0] cnt_ff;
            reg  [15:0] m1_ff;
            reg  [15:0] m2_ff;
            reg  [15:0] c1_ff;
            reg  [15:0] c2_ff;

            // prescaler, output and pin history
            reg  [14:0] div_ff;
            reg         out_ff;
            reg         ext_d_ff;
            reg         cp1_d_ff;
            reg         cp2_d_ff;

            wire mode_cc = mc_ff[`MC_MODE];
            wire run     = mc_ff[`MC_RUN];

            // external clock edge, edge select only matters when selected
            // a pulse shorter than one clock is lost
            // the mode and run bits above steer the whole timer
            wire ext_pin  = i_timer_external_clock_pin[t];
            wire ext_edge = mc_ff[`MC_EXTERNAL_CLOCK_EDGE_SELECT] ? (ext_d_ff & ~ext_pin)
                                               : (~ext_d_ff & ext_pin);
            wire src_tick = mc_ff[`MC_EXTERNAL_CLOCK_ENABLE] ? ext_edge : 1'b1;

            // prescaler: terminal count 2^n - 1, code 0 passes every tick
            // the divider restarts from zero whenever the timer stops
            wire [15:0] div_one = 16'h0001 << psc_ff;
            wire [14:0] div_tc  = div_one[14:0] - 15'h0001;
            wire        pre_tick = run & src_tick & (div_ff == div_tc);

            // capture inputs; tie steers pin 1 to capture 2
            wire cp1_in  = i_first_capture_pin[t];
            wire cp2_src = co_ff[`CO_TIE] ? i_first_capture_pin[t]
                                          : i_second_capture_pin[t];
            wire cp2_in  = cp2_src;

            // enables gate edges, not pins: no fake edge on enable
            wire cp1_en = mc_ff[`MC_CAP1EN];
            wire cp2_en = mc_ff[`MC_CAP2EN];
            wire cp1_r = cp1_en & ~cp1_d_ff & cp1_in;
            wire cp1_f = cp1_en & cp1_d_ff & ~cp1_in;
            wire cp2_r = cp2_en & ~cp2_d_ff & cp2_in;
            wire cp2_f = cp2_en & cp2_d_ff & ~cp2_in;
            wire cap1_ev = (co_ff[1:0] == `EDGE_FALL) ? cp1_f :
                           (co_ff[1:0] == `EDGE_RISE) ? cp1_r : (cp1_f | cp1_r);
            wire cap2_ev = (co_ff[3:2] == `EDGE_FALL) ? cp2_f :
                           (co_ff[3:2] == `EDGE_RISE) ? cp2_r : (cp2_f | cp2_r);

            // counter events; qualified by the tick so that a match is
            // flagged once per pass, not on every system clock
            wire ovf_ev  = pre_tick & (cnt_ff == 16'hffff);
            wire m1_ev   = pre_tick & (cnt_ff == m1_ff);
            wire m2_ev   = pre_tick & (cnt_ff == m2_ff);
            wire c1_ev   = mode_cc & cap1_ev;
            wire c2_ev   = mode_cc & cap2_ev;
            wire sec_ev  = mode_cc ? c2_ev : m2_ev;
            // same bit order as the flag field
            wire [3:0] set_v = {ovf_ev, sec_ev, c1_ev, m1_ev};

            // edge history samples the pins (capture 2 after the tie select) every clock, timer on or off,
            // so re-enabling a timer or an input sees no stale edge
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    ext_d_ff <= 1'b0;
                    cp1_d_ff <= 1'b0;
                    cp2_d_ff <= 1'b0;
                end else begin
                    ext_d_ff <= ext_pin;
                    cp1_d_ff <= cp1_in;
                    cp2_d_ff <= cp2_in;
                end
            end

            // configuration registers
            // match values take the low half-word
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    ie_ff  <= 4'h0;
                    psc_ff <= 4'h0;
                    mc_ff  <= `CFG_RST;
                    co_ff  <= 5'h00;
                    m1_ff  <= `CNT_RST;
                    m2_ff  <= `CNT_RST;
                end else begin
                    if (w_ev) ie_ff  <= wd[7:4];
                    if (w_ps) psc_ff <= wd[3:0];
                    if (w_mc) mc_ff  <= wd;
                    if (w_co) co_ff  <= wd[4:0];
                    if (w_m1) m1_ff  <= i_avs_writedata[15:0];
                    if (w_m2) m2_ff  <= i_avs_writedata[15:0];
                end
            end

            // sticky flags: writing one clears, a same-cycle event still wins
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    flag_ff <= 4'h0;
                end else begin
                    flag_ff <= ((w_ev ? (flag_ff & ~wd[3:0]) : flag_ff)
                               | set_v);
                end
            end

            // prescaler and counter; disabled timer zeroes the divider and holds the count
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    div_ff <= 15'h0000;
                    cnt_ff <= `CNT_RST;
                end else begin
                    if (!run) begin
                        div_ff <= 15'h0000;
                    end else if (src_tick) begin
                        div_ff <= pre_tick ? 15'h0000 : div_ff + 15'h0001;
                    end
                    if (clr_pulse[t]) begin
                        cnt_ff <= `CNT_RST;
                    end else if (c1_ev & mc_ff[`MC_CAPRST]) begin
                        cnt_ff <= `CNT_RST;
                    end else if (pre_tick) begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
            end

            // capture latches
            // a latch takes the count as it stood before the event
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    c1_ff <= `CNT_RST;
                    c2_ff <= `CNT_RST;
                end else begin
                    if (c1_ev) c1_ff <= cnt_ff;
                    if (c2_ev) c2_ff <= cnt_ff;
                end
            end

            // output: force bits override, pwm sets on wrap, clears on match1
            // in capture mode only the force bits move the pin
            always @(posedge i_ref_clk) begin
                if (i_reset) begin
                    out_ff <= 1'b0;
                end else if (w_co & wd[`CO_FORCE_HI]) begin
                    out_ff <= 1'b1;
                end else if (w_co & wd[`CO_FORCE_LO]) begin
                    out_ff <= 1'b0;
                end else if (!mode_cc & m1_ev) begin
                    out_ff <= 1'b0;
                end else if (!mode_cc & ovf_ev) begin
                    out_ff <= 1'b1;
                end
            end

            assign o_timer_output_pin[t]      = out_ff;
            assign o_timer_output_pin_oe_n[t] = ~mc_ff[`MC_OEN];
            assign o_timer_irq[t] = pair_ie_ff[t] & |(ie_ff & flag_ff);

            // read values; override bits are write-only
            // oe_n above is low while the timer drives its pin
            assign rd_evt[t] = {ie_ff, flag_ff};
            assign rd_psc[t] = {4'h0, psc_ff};
            assign rd_mc[t]  = mc_ff;
            assign rd_co[t]  = {3'h0, co_ff};
            assign rd_cnt[t] = cnt_ff;
            assign rd_m1[t]  = m1_ff;
            assign rd_m2[t]  = m2_ff;
            assign rd_c1[t]  = c1_ff;
            assign rd_c2[t]  = c2_ff;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped words read zero
    // sel picks the timer, rel_idx the word within its map
    // words above pair control read zero and drop writes
    reg        sel;
    reg  [4:0] rel_idx;
    reg [31:0] nxt_rdata;
    always @* begin
        sel       = (word_idx >= {1'b0, `TMR_B_BASE});
        rel_idx   = sel ? (word_idx - {1'b0, `TMR_B_BASE}) : word_idx;
        nxt_rdata = 32'h0000_0000;
        if (word_idx == `PAIR_CTRL_IDX) begin
            nxt_rdata = {26'h0, pair_ie_ff, 4'h0};
        end else if (word_idx > `PAIR_CTRL_IDX) begin
            nxt_rdata = 32'h0000_0000;
        end else if (rel_idx == {1'b0, `TMR_EVT_IRQ_IDX}) begin
            nxt_rdata = {24'h0, rd_evt[sel]};
        end else if (rel_idx == {1'b0, `TMR_PRESCALE_IDX}) begin
            nxt_rdata = {24'h0, rd_psc[sel]};
        end else if (rel_idx == {1'b0, `TMR_MODE_CLK_IDX}) begin
            nxt_rdata = {24'h0, rd_mc[sel]};
        end else if (rel_idx == {1'b0, `TMR_CAP_OUT_IDX}) begin
            nxt_rdata = {24'h0, rd_co[sel]};
        end else if (rel_idx == {1'b0, `TMR_COUNT_IDX}) begin
            nxt_rdata = {16'h0, rd_cnt[sel]};
        end else if (rel_idx == {1'b0, `TMR_MATCH1_IDX}) begin
            nxt_rdata = {16'h0, rd_m1[sel]};
        end else if (rel_idx == {1'b0, `TMR_MATCH2_IDX}) begin
            nxt_rdata = {16'h0, rd_m2[sel]};
        end else if (rel_idx == {1'b0, `TMR_CAPT1_IDX}) begin
            nxt_rdata = {16'h0, rd_c1[sel]};
        end else if (rel_idx == {1'b0, `TMR_CAPT2_IDX}) begin
            nxt_rdata = {16'h0, rd_c2[sel]};
        end
    end

    // read data registered in the wait cycle, valid when waitrequest drops
    // it then holds until the next read
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (i_avs_read & ~ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule // dual_timer_capture_compare_pwm

// ==== test/dual_timer_sva.sv ====
// assertion checker for the dual timer block, bound to its top module
`timescale 1ns/1ps
module dual_timer_sva (
    input wire        i_ref_clk,
    input wire        i_reset,
    input wire [6:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0]  i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    input wire [1:0]  o_timer_output_pin,
    input wire [1:0]  o_timer_output_pin_oe_n,
    input wire [1:0]  o_timer_irq
);
    logic [3:0] ie_ff;
    logic       oen_ff;
    logic [1:0] pair_ie_ff;
    wire        wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    wire        rd_ok = i_avs_read && !o_avs_waitrequest;
    wire  [4:0] idx   = i_avs_address[6:2];
    // shadows of timer a enables, so irq and pin enable can be tied to bus writes
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            ie_ff <= 4'h0;
            oen_ff <= 1'b0;
            pair_ie_ff <= 2'h0;
        end else if (wr_ok) begin
            if (idx == 5'h00) ie_ff <= i_avs_writedata[7:4];
            if (idx == 5'h02) oen_ff <= i_avs_writedata[6];
            if (idx == 5'h12) pair_ie_ff <= i_avs_writedata[5:4];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_oe_follows: assert property (o_timer_output_pin_oe_n[0] == !oen_ff)
        else $error("pin enable differs from written bit");
    a_force_high: assert property (wr_ok && idx == 5'h03 && i_avs_writedata[6]
        |=> o_timer_output_pin[0]) else $error("force high not seen");
    a_force_low: assert property (wr_ok && idx == 5'h03 && i_avs_writedata[6:5] == 2'b01
        |=> !o_timer_output_pin[0]) else $error("force low not seen");
    a_force_reads_zero: assert property (rd_ok && idx == 5'h03
        |-> o_avs_readdata[6:5] == 2'b00) else $error("override bits read nonzero");
    a_pair_readback: assert property (rd_ok && idx == 5'h12
        |-> o_avs_readdata[5:0] == {pair_ie_ff, 4'h0}) else $error("pair control readback");
    a_prescale_width: assert property (rd_ok && idx == 5'h01
        |-> o_avs_readdata[31:4] == 28'h0) else $error("prescale upper bits set");
    a_irq_pair_gate: assert property (o_timer_irq[0] |-> pair_ie_ff[0])
        else $error("irq without timer enable");
    a_irq_src_gate: assert property (o_timer_irq[0] |-> ie_ff != 4'h0)
        else $error("irq without event enable");
    c_write: cover property (wr_ok);
    c_irq: cover property (o_timer_irq[0]);
    c_pin: cover property ($rose(o_timer_output_pin[0]));
endmodule // dual_timer_sva

bind dual_timer_capture_compare_pwm dual_timer_sva u_dual_timer_sva (.i_ref_clk, .i_reset,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_timer_output_pin, .o_timer_output_pin_oe_n,
    .o_timer_irq);

// ==== test/pin_model.sv ====
// pin-side model: external clock and capture pins of both timers
`timescale 1ns/1ps
module pin_model (
    input  wire       i_ref_clk,
    output reg  [1:0] o_ext_clk,
    output reg  [1:0] o_cap1,
    output reg  [1:0] o_cap2
);
    // pins idle low until a scenario moves them
    initial begin
        o_ext_clk = 2'h0;
        o_cap1 = 2'h0;
        o_cap2 = 2'h0;
    end
    // level held 3 clocks so the synchronous sampler cannot miss it
    task automatic drive(input int sel, input int tm, input bit lvl);
        @(posedge i_ref_clk);
        case (sel)
            0: o_ext_clk[tm] <= lvl;
            1: o_cap1[tm] <= lvl;
            default: o_cap2[tm] <= lvl;
        endcase
        repeat (3) @(posedge i_ref_clk);
    endtask
endmodule // pin_model

// ==== test/dual_timer_capture_compare_pwm_bench.sv ====
// self-checking bench for the dual timer block
`timescale 1ns/1ps
module dual_timer_capture_compare_pwm_bench;
    logic        i_ref_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [6:0]  i_avs_address = 7'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    wire  [31:0] o_avs_readdata;
    wire         o_avs_waitrequest;
    wire  [1:0]  i_timer_external_clock_pin, i_first_capture_pin, i_second_capture_pin;
    wire  [1:0]  o_timer_output_pin, o_timer_output_pin_oe_n, o_timer_irq;
    logic [31:0] q, v;
    int          bad_count = 0;
    int          n_compared = 0;
    // 250 MHz reference
    always #2 i_ref_clk = ~i_ref_clk;
    dual_timer_capture_compare_pwm u_dual_timer_capture_compare_pwm (.i_ref_clk, .i_reset,
        .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
        .o_avs_readdata, .o_avs_waitrequest, .i_timer_external_clock_pin, .i_first_capture_pin,
        .i_second_capture_pin, .o_timer_output_pin, .o_timer_output_pin_oe_n, .o_timer_irq);
    pin_model u_pin_model (.i_ref_clk, .o_ext_clk(i_timer_external_clock_pin),
        .o_cap1(i_first_capture_pin), .o_cap2(i_second_capture_pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    // one access; hold until waitrequest is seen low, idle edge after release
    task automatic bus(input bit w, input int ix, input int d);
        int n;
        n = 0;
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= 7'(ix * 4);
        i_avs_writedata <= 32'(d);
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_ref_clk);
        if (n >= 20) chk("bus answer", 32'h0, 32'h1);
    endtask
    task automatic wr(input int ix, input int d);
        bus(1'b1, ix, d);
    endtask
    task automatic rd(input int ix);
        bus(1'b0, ix, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            rd(i);
            chk("reset reg", 32'h0, q);
        end
        chk("reset oe_n", 32'h3, o_timer_output_pin_oe_n);
        wr(5'h13, 8'hff);
        rd(5'h13);
        chk("unmapped", 32'h0, q);
        i_avs_byteenable <= 4'he;
        wr(1, 8'h0f);
        i_avs_byteenable <= 4'hf;
        rd(1);
        chk("lane0 off", 32'h0, q);
        $display("t_reset done");
    endtask
    task automatic t_match();
        wr(5'h12, 8'h33);
        rd(5'h12);
        chk("pair readback", 32'h30, q);
        rd(4);
        chk("count cleared", 32'h0, q);
        wr(5, 5);
        wr(6, 7);
        wr(0, 8'h10);
        wr(2, 8'h01);
        repeat (20) @(posedge i_ref_clk);
        rd(0);
        chk("match flags", 32'h15, q);
        chk("irq match", 32'h1, o_timer_irq[0]);
        wr(5'h12, 8'h00);
        chk("irq pair off", 32'h0, o_timer_irq[0]);
        wr(0, 8'h05);
        rd(0);
        chk("flags cleared", 32'h0, q);
        wr(2, 0);
        rd(4);
        v = q;
        repeat (10) @(posedge i_ref_clk);
        rd(4);
        chk("count held", v, q);
        $display("t_match done");
    endtask
    task automatic t_presc();
        int e;
        for (int c = 0; c < 5; c++) begin
            wr(2, 0);
            wr(5'h12, 1);
            wr(1, c);
            wr(2, 1);
            repeat (61) @(posedge i_ref_clk);
            wr(2, 0);
            rd(4);
            e = 64 >> c;
            chk("prescaled count", 32'(e), q);
        end
        $display("t_presc done");
    endtask
    task automatic t_ext();
        wr(1, 0);
        for (int e = 0; e < 2; e++) begin
            wr(2, 0);
            wr(5'h12, 1);
            wr(2, 8'h21 | (e << 2));
            u_pin_model.drive(0, 0, 1'b1);
            rd(4);
            chk("ext rise", 32'(e == 0), q);
            u_pin_model.drive(0, 0, 1'b0);
            rd(4);
            chk("ext fall", 32'h1, q);
        end
        $display("t_ext done");
    endtask
    task automatic t_capture();
        wr(2, 8'h89);
        for (int c = 0; c < 4; c++) begin
            wr(3, c);
            wr(0, 8'h0f);
            u_pin_model.drive(1, 0, 1'b1);
            rd(0);
            chk("cap rise", 32'(c != 0), q[1]);
            wr(0, 8'h0f);
            u_pin_model.drive(1, 0, 1'b0);
            rd(0);
            chk("cap fall", 32'(c != 1), q[1]);
        end
        wr(2, 8'h8b);
        repeat (50) @(posedge i_ref_clk);
        u_pin_model.drive(1, 0, 1'b1);
        rd(4);
        chk("cap clears", 32'h1, q < 12);
        wr(2, 8'h81);
        wr(0, 8'h0f);
        u_pin_model.drive(1, 0, 1'b0);
        rd(0);
        chk("cap off", 32'h0, q[1]);
        wr(3, 8'h04);
        wr(2, 8'h91);
        wr(0, 8'h0f);
        u_pin_model.drive(2, 0, 1'b1);
        rd(0);
        chk("cap2 pin", 32'h1, q[2]);
        wr(3, 8'h14);
        wr(2, 8'h99);
        wr(0, 8'h0f);
        u_pin_model.drive(1, 0, 1'b1);
        rd(0);
        chk("cap2 tied", 32'h1, q[2]);
        $display("t_capture done");
    endtask
    task automatic t_output();
        for (int t = 0; t < 2; t++) begin
            wr(t * 9 + 2, 8'h40);
            chk("oe on", 32'h0, o_timer_output_pin_oe_n[t]);
            wr(t * 9 + 3, 8'h40);
            chk("force high", 32'h1, o_timer_output_pin[t]);
            rd(t * 9 + 3);
            chk("override read", 32'h0, q[6:5]);
            wr(t * 9 + 3, 8'h20);
            chk("force low", 32'h0, o_timer_output_pin[t]);
            wr(t * 9 + 3, 8'h60);
            chk("force both", 32'h1, o_timer_output_pin[t]);
            wr(t * 9 + 2, 0);
            chk("oe off", 32'h1, o_timer_output_pin_oe_n[t]);
        end
        $display("t_output done");
    endtask
    // one full wrap of the 16-bit counter, the longest scenario
    task automatic t_overflow();
        wr(2, 0);
        wr(5'h12, 8'h11);
        wr(1, 0);
        wr(0, 8'h80);
        wr(2, 1);
        repeat (65536) @(posedge i_ref_clk);
        rd(0);
        chk("ovf flag", 32'h88, q & 32'hf8);
        chk("ovf irq", 32'h1, o_timer_irq[0]);
        rd(4);
        chk("wrapped", 32'h1, q < 16);
        wr(0, 8'h08);
        chk("ovf irq off", 32'h0, o_timer_irq[0]);
        $display("t_overflow done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_reset();
        t_match();
        t_presc();
        t_ext();
        t_capture();
        t_output();
        t_overflow();
        test_done();
    end
    // run needs about 66300 clocks; well past that counts as a hang
    initial begin
        repeat (80000) @(posedge i_ref_clk);
        bad_count++;
        test_done();
    end
endmodule // dual_timer_capture_compare_pwm_bench
